// [hdl/rwc_top.sv]
// reset sequencer, cause flags, usb address and watchdog of the microcontroller
// Behaviour
// R1 - three reset sources: supply, watchdog, usb bus
// R2 - any reset restores defaults, addresses, interrupts off
// R3 - reset zeroes program and data stack pointers
// R4 - firmware moves data stack below buffers
// R5 - three cause bits in status register
// R6 - supply or watchdog reset starts at zero
// R7 - reset entry pushes nothing onto program stack
// R8 - firmware never returns from reset handler
// R9 - supply start sets bit four
// R10 - supply start forces ports to input
// R11 - idle lines with pin high enter suspend
// R12 - pin high after suspend gives short delay
// R13 - pin low gives long delay then run; code gives the long delay only with the supply flag set, else short
// R14 - delay choice: pin, then flag, then short
// R15 - firmware clears supply flag before suspend
// R16 - watchdog msb rising causes watchdog reset
// R17 - watchdog reset sets bit six
// R18 - watchdog advances on timer bit eleven
// R19 - any write to clear port zeroes watchdog
// R20 - watchdog reset held 2.048 ms
// R21 - watchdog clears usb address, transmitter off
// R22 - indexed write adds x to address
// R23 - bus reset skips delays; every reset clears watchdog; a bus reset in suspend takes the start-up delay
`timescale 1ns/10ps
`default_nettype none
module rwc_top
    import rwc_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_START_CYC, // 128 us start-up
    parameter int LONG_CYC = LONG_START_CYC, // 96 ms start-up
    parameter int HOLD_CYC = WDR_HOLD_CYC // 2.048 ms watchdog hold
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire rwc_pkg::rwc_io_req_t io_req,
    output logic [7:0] io_rdata,
    input wire logic timer_bit11,
    input wire logic usb_bus_reset,
    input wire rwc_pkg::rwc_usb_lines_t usb_lines,
    input wire logic port3_bit7,
    output logic core_reset,
    output logic gpio_hiz,
    output logic suspend,
    output logic usb_tx_enable,
    output logic [7:0] usb_device_address
);
    import rwc_pkg::*;

    // all state of the top
    typedef struct packed {
        rwc_state_e_t st;
        logic [7:0] psc;
        logic [7:0] usb_addr;
        logic [7:0] rdata;
        logic core_reset;
        logic gpio_hiz;
        logic suspend;
        logic dly_load;
        logic [DLY_W-1:0] dly_val;
        logic wd_clear;
    } rwc_top_t;

    // reset value: supply start seen, cpu held, ports floated
    localparam rwc_top_t TOP_RESET = '{
        st: RWC_ST_EVAL,
        psc: PSC_RESET,
        usb_addr: USB_ADDR_RESET,
        rdata: 8'h00,
        core_reset: 1'b1,
        gpio_hiz: 1'b1,
        suspend: 1'b0,
        dly_load: 1'b0,
        dly_val: '0,
        wd_clear: 1'b1
    };

    rwc_top_t r; // registered state
    rwc_top_t next_r; // next state
    logic wd_expire; // watchdog counter msb rose
    logic dly_done; // start-up or hold time over
    logic [7:0] eff_addr; // port address after indexing
    logic wr_hit; // a write reaches this block
    logic lines_idle; // usb lines at idle
    logic [7:0] set_bits; // cause bits that hardware sets now

    // watchdog counter
    rwc_watchdog u_watchdog (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .tick(timer_bit11),
        .clear(r.wd_clear),
        .expire(wd_expire)
    );

    // start-up and hold timer
    rwc_delay u_delay (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .load(r.dly_load),
        .value(r.dly_val),
        .done(dly_done)
    );

    // pick the start-up time from the pin and the supply flag
    function automatic logic [DLY_W-1:0] pick_delay(input logic pin, input logic flag);
        logic [DLY_W-1:0] v;
        if (pin)
        begin
            v = DLY_W'(SHORT_CYC); // [R12] [R14]
        end
        else if (flag)
        begin
            v = DLY_W'(LONG_CYC); // [R13] [R14]
        end
        else
        begin
            v = DLY_W'(SHORT_CYC); // [R14]
        end
        return v;
    endfunction

    // port address decode and line state
    always_comb
    begin
        // indexed writes add x; with address zero x alone selects [R22]
        eff_addr = io_req.indexed ? (io_req.addr + io_req.x) : io_req.addr;
        wr_hit = io_req.wr && (r.st == RWC_ST_RUN);
        // low-speed idle: minus line high, plus line low
        lines_idle = usb_lines.dm && !usb_lines.dp;
    end

    // next-state logic of the sequencer and the registers
    always_comb
    begin
        next_r = r;
        next_r.dly_load = 1'b0;
        next_r.wd_clear = 1'b0;
        set_bits = 8'h00;

        // firmware writes to the usb address and the status register
        if (wr_hit && eff_addr == ADDR_USB_DEVICE_ADDRESS)
        begin
            next_r.usb_addr = io_req.wdata; // msb re-enables transmitter [R21]
        end
        if (wr_hit && eff_addr == ADDR_PROCESSOR_STATUS_CONTROL)
        begin
            next_r.psc = io_req.wdata & PSC_MASK; // firmware may clear flags [R15]
        end
        // any value written to the clear port zeroes the counter
        if (wr_hit && eff_addr == ADDR_WATCHDOG_CLEAR_PORT)
        begin
            next_r.wd_clear = 1'b1; // [R19]
        end

        // read data, registered for the next cycle
        next_r.rdata = 8'h00;
        if (io_req.rd && r.st == RWC_ST_RUN)
        begin
            case (eff_addr)
                ADDR_USB_DEVICE_ADDRESS: next_r.rdata = r.usb_addr;
                ADDR_PROCESSOR_STATUS_CONTROL: next_r.rdata = r.psc;
                default: next_r.rdata = 8'h00; // write-only or foreign port
            endcase
        end

        // reset sequencer
        case (r.st)
            // just out of supply start: decide between suspend and delay
            RWC_ST_EVAL:
            begin
                next_r.core_reset = 1'b1;
                next_r.gpio_hiz = 1'b1; // [R10]
                next_r.wd_clear = 1'b1; // [R23]
                if (port3_bit7 && lines_idle)
                begin
                    next_r.st = RWC_ST_SUSPEND; // [R11]
                    next_r.suspend = 1'b1;
                end
                else
                begin
                    next_r.st = RWC_ST_DELAY;
                    next_r.dly_load = 1'b1;
                    next_r.dly_val = pick_delay(port3_bit7, r.psc[BIT_SUPPLY_START]);
                end
            end
            // powered down until bus reset, resume or single-ended zero
            RWC_ST_SUSPEND:
            begin
                next_r.wd_clear = 1'b1; // [R23]
                if (!lines_idle || usb_bus_reset)
                begin
                    next_r.st = RWC_ST_DELAY; // [R11]
                    next_r.suspend = 1'b0;
                    next_r.dly_load = 1'b1;
                    next_r.dly_val = pick_delay(port3_bit7, r.psc[BIT_SUPPLY_START]);
                end
            end
            // cpu held while the supply or resonator settles
            RWC_ST_DELAY:
            begin
                next_r.wd_clear = 1'b1; // [R23]
                if (dly_done)
                begin
                    next_r.st = RWC_ST_RUN;
                    next_r.core_reset = 1'b0; // fetch starts at address zero [R6]
                    next_r.gpio_hiz = 1'b0;
                end
            end
            // watchdog reset held for its fixed time
            RWC_ST_WDR_HOLD:
            begin
                next_r.wd_clear = 1'b1; // [R23]
                if (dly_done)
                begin
                    next_r.st = RWC_ST_RUN;
                    next_r.core_reset = 1'b0; // [R6] [R20]
                end
            end
            // normal execution
            RWC_ST_RUN:
            begin
                next_r.core_reset = 1'b0;
                if (wd_expire)
                begin
                    // watchdog reset: hold core, clear address [R16] [R20] [R21]
                    next_r.st = RWC_ST_WDR_HOLD;
                    next_r.core_reset = 1'b1;
                    next_r.usb_addr = USB_ADDR_RESET;
                    next_r.dly_load = 1'b1;
                    next_r.dly_val = DLY_W'(HOLD_CYC);
                    next_r.wd_clear = 1'b1; // [R23]
                    set_bits[BIT_WATCHDOG] = 1'b1; // [R17] [R5]
                end
                else if (usb_bus_reset)
                begin
                    // bus reset: one cycle of init, no start-up delay [R23]
                    next_r.core_reset = 1'b1;
                    next_r.usb_addr = USB_ADDR_RESET; // [R2]
                    next_r.wd_clear = 1'b1; // [R23]
                    set_bits[BIT_USB_RESET] = 1'b1; // [R5]
                end
            end
            default:
            begin
                next_r.st = RWC_ST_EVAL;
                next_r.core_reset = 1'b1;
            end
        endcase

        // hardware set wins over a firmware clear in the same cycle
        next_r.psc = next_r.psc | set_bits; // [R5]
    end

    // register the state; supply start loads the defaults [R1] [R9]
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= TOP_RESET;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    // core_reset zeroes pc, both stack pointers, registers, interrupt
    // enables; it forces no stack write, so the program stack pointer stays at zero [R2] [R3] [R7]
    assign core_reset = r.core_reset;
    assign gpio_hiz = r.gpio_hiz;
    assign suspend = r.suspend;
    assign io_rdata = r.rdata;
    assign usb_device_address = r.usb_addr;
    assign usb_tx_enable = r.usb_addr[BIT_USB_TX_EN]; // [R21]
endmodule // rwc_top
`default_nettype wire

// [pkg/rwc_pkg.sv]
// package of constants and types for the reset and watchdog control block
package rwc_pkg;
    // clock rate in MHz
    localparam int CLK_MHZ = 100;
    // start-up and hold times, each in its own unit
    localparam int SHORT_START_US = 128;
    localparam int LONG_START_MS = 96;
    localparam int WDR_HOLD_US = 2048;
    // derived cycle counts
    localparam int SHORT_START_CYC = SHORT_START_US * CLK_MHZ;
    localparam int LONG_START_CYC = LONG_START_MS * 1000 * CLK_MHZ;
    localparam int WDR_HOLD_CYC = WDR_HOLD_US * CLK_MHZ;
    // width of the delay counter, big enough for the long start-up
    localparam int DLY_W = 24;
    // port addresses
    localparam logic [7:0] ADDR_USB_DEVICE_ADDRESS = 8'h10;
    localparam logic [7:0] ADDR_WATCHDOG_CLEAR_PORT = 8'h26;
    localparam logic [7:0] ADDR_PROCESSOR_STATUS_CONTROL = 8'hFF;
    // cause flag positions in the status register
    localparam int BIT_SUPPLY_START = 4;
    localparam int BIT_USB_RESET = 5;
    localparam int BIT_WATCHDOG = 6;
    // usb address bit that enables the transmitter
    localparam int BIT_USB_TX_EN = 7;
    // reset values, status write mask and watchdog compare value
    localparam logic [7:0] PSC_RESET = 8'h10;
    localparam logic [7:0] PSC_MASK = 8'h70;
    localparam logic [7:0] USB_ADDR_RESET = 8'h00;
    localparam logic [1:0] WD_MSB_SET = 2'h1;
    // sequencer states
    typedef enum logic [2:0] {
        RWC_ST_EVAL,
        RWC_ST_SUSPEND,
        RWC_ST_DELAY,
        RWC_ST_WDR_HOLD,
        RWC_ST_RUN
    } rwc_state_e_t;
    // one port access from the cpu core
    typedef struct packed {
        logic wr;
        logic rd;
        logic indexed;
        logic [7:0] addr;
        logic [7:0] x;
        logic [7:0] wdata;
    } rwc_io_req_t;
    // usb line levels
    typedef struct packed {
        logic dm;
        logic dp;
    } rwc_usb_lines_t;
endpackage

// [hdl/rwc_watchdog.sv]
// two-bit watchdog counter advanced by the timer tick
`timescale 1ns/10ps
`default_nettype none
module rwc_watchdog
    import rwc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic tick,
    input wire logic clear,
    output logic expire
);
    // all state of the counter
    typedef struct packed {
        logic tick_d;
        logic [1:0] cnt;
        logic expire;
    } rwc_wd_t;
    rwc_wd_t r;
    rwc_wd_t next_r;
    logic adv;

    // advance on each rising edge of the timer bit
    always_comb
    begin
        next_r = r;
        adv = tick && !r.tick_d; // [R18]
        next_r.tick_d = tick;
        next_r.expire = 1'b0;
        if (clear)
        begin
            next_r.cnt = 2'h0; // [R19]
        end
        else if (adv)
        begin
            next_r.cnt = r.cnt + 2'h1;
            next_r.expire = (r.cnt == WD_MSB_SET); // msb goes low to high [R16]
        end
    end

    // register the state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= '0;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    assign expire = r.expire;
endmodule // rwc_watchdog
`default_nettype wire

// [hdl/rwc_delay.sv]
// down-counting delay timer with a done pulse
`timescale 1ns/10ps
`default_nettype none
module rwc_delay
    import rwc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic load,
    input wire logic [DLY_W-1:0] value,
    output logic done
);
    // all state of the timer
    typedef struct packed {
        logic busy;
        logic [DLY_W-1:0] cnt;
        logic done;
    } rwc_dly_t;
    rwc_dly_t r;
    rwc_dly_t next_r;

    // done fires value cycles after the load
    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        if (load)
        begin
            next_r.cnt = value;
            next_r.busy = 1'b1;
        end
        else if (r.busy)
        begin
            if (r.cnt <= DLY_W'(1))
            begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end
            else
            begin
                next_r.cnt = r.cnt - DLY_W'(1);
            end
        end
    end

    // register the state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= '0;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    assign done = r.done;
endmodule // rwc_delay
`default_nettype wire

// [tb/rwc_top_asserts.sv]
// port assertions for the reset and watchdog control block
`timescale 1ns/10ps
`default_nettype none
module rwc_top_asserts
    import rwc_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_START_CYC,
    parameter int LONG_CYC = LONG_START_CYC,
    parameter int HOLD_CYC = WDR_HOLD_CYC
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire rwc_pkg::rwc_io_req_t io_req,
    input wire logic [7:0] io_rdata,
    input wire logic timer_bit11,
    input wire logic usb_bus_reset,
    input wire rwc_pkg::rwc_usb_lines_t usb_lines,
    input wire logic port3_bit7,
    input wire logic core_reset,
    input wire logic gpio_hiz,
    input wire logic suspend,
    input wire logic usb_tx_enable,
    input wire logic [7:0] usb_device_address
);
    // one clock domain, supply reset disables all
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // cpu stays held at the start of the start-up delay after suspend, short or long
    sequence short_hold_s;
        core_reset [*8];
    endsequence
    // bus reset gives a single-cycle cpu reset
    sequence bus_pulse_s;
        core_reset ##1 !core_reset;
    endsequence
    tx_follow_a: assert property (usb_tx_enable == usb_device_address[7])
        else $error("tx enable differs from address msb");
    hiz_core_a: assert property (gpio_hiz |-> core_reset)
        else $error("ports floated while cpu runs");
    hiz_rel_a: assert property ($fell(gpio_hiz) |-> $fell(core_reset))
        else $error("ports and cpu released apart");
    susp_entry_a: assert property ($rose(suspend) |-> $past(port3_bit7)
        && $past(usb_lines.dm) && !$past(usb_lines.dp))
        else $error("suspend without strap and idle lines");
    short_hold_a: assert property ($fell(suspend) |-> short_hold_s)
        else $error("cpu started without start-up delay");
    bus_pulse_a: assert property (usb_bus_reset && !core_reset |-> ##[1:2] bus_pulse_s)
        else $error("bus reset pulse wrong");
    bus_addr_a: assert property (usb_bus_reset && !core_reset |->
        ##[1:3] usb_device_address == 8'h00)
        else $error("bus reset kept usb address");
    rd_idle_a: assert property (!io_req.rd |=> io_rdata == 8'h00)
        else $error("read data without read");
    rd_status_a: assert property (io_req.rd && !io_req.indexed && io_req.addr == 8'hFF
        |=> (io_rdata & 8'h8F) == 8'h00)
        else $error("status reads outside cause bits");
    rd_wdclr_a: assert property (io_req.rd && !io_req.indexed && io_req.addr == 8'h26
        |=> io_rdata == 8'h00)
        else $error("clear port is readable");
endmodule // rwc_top_asserts
bind rwc_top rwc_top_asserts #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC),
    .HOLD_CYC(HOLD_CYC)) u_chk (.clk(clk), .reset_n(reset_n), .ce(ce), .io_req(io_req),
    .io_rdata(io_rdata), .timer_bit11(timer_bit11), .usb_bus_reset(usb_bus_reset),
    .usb_lines(usb_lines), .port3_bit7(port3_bit7), .core_reset(core_reset),
    .gpio_hiz(gpio_hiz), .suspend(suspend), .usb_tx_enable(usb_tx_enable),
    .usb_device_address(usb_device_address));
`default_nettype wire

// [tb/rwc_cpu_model.sv]
// cpu firmware model issuing port reads and writes
`timescale 1ns/10ps
`default_nettype none
module rwc_cpu_model
    import rwc_pkg::*;
(
    input wire logic clk,
    output var rwc_pkg::rwc_io_req_t io_req,
    input wire logic [7:0] io_rdata
);
    // bus idle from time zero
    initial io_req = '0;
    // one port access; only port instructions, never a return from reset
    // data stack placement below the endpoint buffers is firmware work that
    // never reaches this block's ports, so the model issues no such access
    task automatic io_op(input logic wr, input logic idx, input logic [7:0] a,
        input logic [7:0] x, input logic [7:0] w, output logic [7:0] d);
        @(negedge clk);
        io_req = '{wr: wr, rd: !wr, indexed: idx, addr: a, x: x, wdata: w};
        @(negedge clk);
        // read data stands only in the cycle after the strobe edge
        d = io_rdata;
        // released fields no longer show the old value
        io_req = '{wr: 1'b0, rd: 1'b0, indexed: !idx, addr: ~a, x: ~x, wdata: ~w};
    endtask
endmodule // rwc_cpu_model
`default_nettype wire

// [tb/rwc_top_tb_top.sv]
// self-checking bench for the reset and watchdog control block
`timescale 1ns/10ps
`default_nettype none
module rwc_top_tb_top;
    import rwc_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic timer_bit11 = 1'b0;
    logic usb_bus_reset = 1'b0;
    rwc_usb_lines_t usb_lines = 2'b10;
    logic port3_bit7 = 1'b0;
    rwc_io_req_t io_req;
    logic [7:0] io_rdata, usb_device_address, rd;
    logic core_reset, gpio_hiz, suspend, usb_tx_enable;
    int errors = 0;
    int compares = 0;
    int n;
    // 100 MHz clock
    always #5 clk = ~clk;
    rwc_top #(.SHORT_CYC(20), .LONG_CYC(50), .HOLD_CYC(30)) dut (.clk(clk),
        .reset_n(reset_n), .ce(1'b1), .io_req(io_req), .io_rdata(io_rdata),
        .timer_bit11(timer_bit11), .usb_bus_reset(usb_bus_reset), .usb_lines(usb_lines),
        .port3_bit7(port3_bit7), .core_reset(core_reset), .gpio_hiz(gpio_hiz),
        .suspend(suspend), .usb_tx_enable(usb_tx_enable),
        .usb_device_address(usb_device_address));
    rwc_cpu_model cpu (.clk(clk), .io_req(io_req), .io_rdata(io_rdata));
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic results;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // supply-start reset held 20 cycles with a given strap
    task automatic supply_reset(input logic strap);
        @(negedge clk);
        reset_n = 1'b0;
        port3_bit7 = strap;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
    endtask
    // cycles until the cpu leaves reset
    task automatic wait_run;
        n = 0;
        while (core_reset !== 1'b0 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    // one rising edge on the timer tap
    task automatic tick;
        @(negedge clk);
        timer_bit11 = 1'b1;
        repeat (2) @(negedge clk);
        timer_bit11 = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // strap low: long delay, supply flag, defaults
    task automatic t_long;
        supply_reset(1'b0);
        check({7'h0, gpio_hiz}, 8'h01);
        wait_run;
        check({7'h0, n >= 50 && n <= 56}, 8'h01);
        check({7'h0, gpio_hiz}, 8'h00);
        cpu.io_op(1'b0, 1'b0, 8'hFF, 8'h00, 8'h00, rd);
        check(rd, 8'h10);
        cpu.io_op(1'b0, 1'b0, 8'h10, 8'h00, 8'h00, rd);
        check(rd, 8'h00);
        cpu.io_op(1'b0, 1'b0, 8'h26, 8'h00, 8'h00, rd);
        check(rd, 8'h00);
    endtask
    // indexed write with zero encoded address sets usb address
    task automatic t_addr;
        cpu.io_op(1'b1, 1'b1, 8'h00, 8'h10, 8'h85, rd);
        cpu.io_op(1'b0, 1'b0, 8'h10, 8'h00, 8'h00, rd);
        check(rd, 8'h85);
        check({7'h0, usb_tx_enable}, 8'h01);
    endtask
    // clear port delays expiry, then watchdog reset
    task automatic t_wdog;
        tick;
        cpu.io_op(1'b1, 1'b0, 8'h26, 8'h00, 8'h5A, rd);
        tick;
        check({7'h0, core_reset}, 8'h00);
        tick;
        check({7'h0, core_reset}, 8'h01);
        wait_run;
        check({7'h0, n >= 28 && n <= 34}, 8'h01);
        cpu.io_op(1'b0, 1'b0, 8'hFF, 8'h00, 8'h00, rd);
        check(rd, 8'h50);
        check(usb_device_address, 8'h00);
        check({7'h0, usb_tx_enable}, 8'h00);
    endtask
    // bus reset: flag, address cleared, no start-up delay
    task automatic t_bus;
        cpu.io_op(1'b1, 1'b0, 8'hFF, 8'h00, 8'h00, rd);
        cpu.io_op(1'b1, 1'b0, 8'h10, 8'h00, 8'h05, rd);
        @(negedge clk);
        usb_bus_reset = 1'b1;
        @(negedge clk);
        usb_bus_reset = 1'b0;
        wait_run;
        check({7'h0, n <= 2}, 8'h01);
        cpu.io_op(1'b0, 1'b0, 8'hFF, 8'h00, 8'h00, rd);
        check(rd, 8'h20);
        check(usb_device_address, 8'h00);
    endtask
    // strap high and idle lines: suspend, then short delay on se0
    task automatic t_susp;
        usb_lines = 2'b10;
        supply_reset(1'b1);
        repeat (40) @(negedge clk);
        check({6'h0, suspend, core_reset}, 8'h03);
        usb_lines = 2'b00;
        wait_run;
        check({7'h0, n >= 20 && n <= 26}, 8'h01);
        check({7'h0, suspend}, 8'h00);
        usb_lines = 2'b10;
        // suspend again, then a bus reset wakes it with the strap now low
        supply_reset(1'b1);
        repeat (10) @(negedge clk);
        check({7'h0, suspend}, 8'h01);
        port3_bit7 = 1'b0;
        usb_bus_reset = 1'b1;
        @(negedge clk);
        usb_bus_reset = 1'b0;
        wait_run;
        check({7'h0, n >= 50 && n <= 56}, 8'h01);
        check({7'h0, suspend}, 8'h00);
    endtask
    // main sequence
    initial
    begin
        t_long;
        t_addr;
        t_wdog;
        t_bus;
        t_susp;
        results;
    end
    // cut a hang short
    initial
    begin
        #100us;
        errors++;
        results;
    end
endmodule // rwc_top_tb_top
`default_nettype wire
